// ### motion_cmd_pkg.sv
// Shared constants for the accumulator motion command block
package motion_cmd_pkg;

  // Opcodes handled here
  localparam logic [7:0] OP_MOVE_ACCU_POS   = 8'h2E;
  localparam logic [7:0] OP_ROTATE_LEFT_ACC = 8'h32;
  localparam logic [7:0] OP_ROTATE_RIGHT_ACC = 8'h33;
  localparam logic [7:0] OP_SET_INDEXED_VAR = 8'h37;

  // Move types
  localparam logic [7:0] ABSOLUTE_MOVE_TYPE   = 8'h00;
  localparam logic [7:0] RELATIVE_MOVE_TYPE   = 8'h01;
  localparam logic [7:0] STORED_STORED_COORDINATE_TYPE_TYPE    = 8'h02;

  // Frame layout
  localparam logic [3:0] FRAME_LAST   = 4'h8;
  localparam logic [3:0] REPLY_LAST   = 4'h8;
  localparam logic [7:0] STATUS_OK    = 8'h64;
  localparam logic [7:0] DEF_MOD_ADDR = 8'h01;
  localparam logic [7:0] DEF_HOST_ADDR = 8'h02;

  // Register offsets
  localparam logic [7:0] REG_ACCU       = 8'h00;
  localparam logic [7:0] REG_XREG       = 8'h04;
  localparam logic [7:0] REG_TGT_POS    = 8'h08;
  localparam logic [7:0] REG_TGT_VEL    = 8'h0C;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_UVAR_IDX   = 8'h14;
  localparam logic [7:0] REG_UVAR_DATA  = 8'h18;
  localparam logic [7:0] REG_STORED_COORDINATE_TYPE_IDX  = 8'h1C;
  localparam logic [7:0] REG_STORED_COORDINATE_TYPE_DATA = 8'h20;

  // Status register fields
  localparam int ST_VEL_MODE  = 0;
  localparam int ST_DIR_RIGHT = 1;
  localparam int ST_SIV_IGN   = 2;

  // Memory shape
  localparam int MEM_DEPTH = 256;
  localparam int MEM_AW    = 8;
  localparam int WORD_W    = 32;

endpackage : motion_cmd_pkg

// ### word_mem.sv
// Single write port, registered read port word memory
module word_mem #(
  parameter int W = 32,
  parameter int D = 256,
  parameter int AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem [D];

  // No reset on contents; read data registered
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : word_mem

// ### accu_motion_cmd.sv
// Accumulator driven motion commands and indexed variable store
// Operation
// R01: Opcode 46 moves from accumulator; type 0 abs, 1 rel, 2 stored coordinate
// R02: Move is non-blocking; reply sent right after target load, next command accepted
// R03: Relative move target equals actual position plus accumulator
// R04: Coordinate move uses stored coordinate selected by bank field
// R05: Move loads accumulator value into target position
// R06: Position arithmetic wraps at 32 bits; commander keeps distance in range
// R07: Rotate commands or stop input abort a positioning move; a stop in the cycle a move loads its target loses to the move
// R08: Opcode 50 rotates left, decreasing position; other fields ignored
// R09: Opcode 51 rotates right, increasing position; other fields ignored
// R10: Rotate selects velocity mode, then loads accumulator as target velocity
// R11: Rotate velocity is microsteps per second, passed through unscaled
// R12: Opcode 55 stores value field into user variable indexed by X
// R13: X outside 0 to 255 leaves every user variable untouched
// R14: Frame is address, opcode, type, bank, four value bytes, 8-bit sum
// R15: Host commands get reply with status 100 and value zero
module accu_motion_cmd #(
  parameter logic [7:0] MOD_ADDR  = motion_cmd_pkg::DEF_MOD_ADDR,
  parameter logic [7:0] HOST_ADDR = motion_cmd_pkg::DEF_HOST_ADDR
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Host byte stream
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  output logic [7:0]       tx_byte_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  // Stored program command port
  input  wire logic        prog_valid_i,
  input  wire logic [7:0]  prog_instr_i,
  input  wire logic [7:0]  prog_type_i,
  input  wire logic [7:0]  prog_bank_i,
  input  wire logic [31:0] prog_value_i,
  output logic             prog_ready_o,
  output logic             prog_done_o,
  // Motion controller side
  input  wire logic [31:0] act_pos_i,
  input  wire logic        stop_req_i,
  output logic [31:0]      target_pos_o,
  output logic [31:0]      target_vel_o,
  output logic             vel_mode_o,
  output logic             dir_right_o,
  output logic             pos_load_o,
  output logic             vel_load_o,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [31:0]      reg_rdata_o
);

  typedef enum logic [1:0] {
    S_RX,
    S_EXEC,
    S_STORED_COORDINATE_TYPE,
    S_REPLY
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [3:0]  cnt;
    logic        addr_ok;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] val;
    logic [7:0]  sum;
    logic        from_host;
    logic [3:0]  txcnt;
    logic [7:0]  txsum;
    logic [7:0]  tx_byte;
    logic        tx_valid;
    logic        rx_ready;
    logic        prog_ready;
    logic        done;
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [31:0] tgt_pos;
    logic [31:0] tgt_vel;
    logic        vel_mode;
    logic        dir_right;
    logic        pos_load;
    logic        vel_load;
    logic        siv_ign;
    logic [31:0] rdata;
    logic [7:0]  uvar_idx;
    logic [31:0] uvar_rd;
    logic [7:0]  stored_coordinate_type_idx;
  } core_t;

  core_t       s_ff;
  core_t       nxt_s;
  logic        uv_we;
  logic [7:0]  uv_wa;
  logic [31:0] uv_wd;
  logic [31:0] uv_q;
  logic        co_we;
  logic [31:0] co_q;
  logic [7:0]  rx_b;
  logic [7:0]  tx_b;

  function automatic logic known_op(input logic [7:0] op, input logic [7:0] ty);
    known_op = (op == motion_cmd_pkg::OP_ROTATE_LEFT_ACC) ||
               (op == motion_cmd_pkg::OP_ROTATE_RIGHT_ACC) ||
               (op == motion_cmd_pkg::OP_SET_INDEXED_VAR) ||
               ((op == motion_cmd_pkg::OP_MOVE_ACCU_POS) &&
                (ty <= motion_cmd_pkg::STORED_STORED_COORDINATE_TYPE_TYPE));
  endfunction : known_op

  // User variables, written only by the indexed store
  word_mem #(
    .W  (motion_cmd_pkg::WORD_W),
    .D  (motion_cmd_pkg::MEM_DEPTH),
    .AW (motion_cmd_pkg::MEM_AW)
  ) u_uvar (
    .clk_i   (clk_i),
    .we_i    (uv_we),
    .waddr_i (uv_wa),
    .wdata_i (uv_wd),
    .raddr_i (s_ff.uvar_idx),
    .rdata_o (uv_q)
  );

  // Stored coordinates; read address is the latched bank field
  word_mem #(
    .W  (motion_cmd_pkg::WORD_W),
    .D  (motion_cmd_pkg::MEM_DEPTH),
    .AW (motion_cmd_pkg::MEM_AW)
  ) u_stored_coordinate_type (
    .clk_i   (clk_i),
    .we_i    (co_we),
    .waddr_i (s_ff.stored_coordinate_type_idx),
    .wdata_i (reg_wdata_i),
    .raddr_i (s_ff.bank),
    .rdata_o (co_q)
  );

  always_comb begin
    nxt_s = s_ff;
    uv_we = 1'b0;
    uv_wa = s_ff.xreg[7:0];
    uv_wd = s_ff.val;
    co_we = 1'b0;
    rx_b  = rx_byte_i;
    tx_b  = 8'h00;
    nxt_s.pos_load = 1'b0;
    nxt_s.vel_load = 1'b0;
    nxt_s.done     = 1'b0;
    nxt_s.rdata    = 32'h0000_0000;
    nxt_s.uvar_rd  = uv_q;

    // R07 external stop ends positioning
    if (stop_req_i) begin
      nxt_s.vel_mode = 1'b1;
      nxt_s.tgt_vel  = 32'h0000_0000;
      nxt_s.vel_load = 1'b1;
    end

    // Register writes
    if (reg_we_i) begin
      unique case (reg_addr_i)
        motion_cmd_pkg::REG_ACCU:       nxt_s.accu = reg_wdata_i;
        motion_cmd_pkg::REG_XREG:       nxt_s.xreg = reg_wdata_i;
        motion_cmd_pkg::REG_UVAR_IDX:   nxt_s.uvar_idx = reg_wdata_i[7:0];
        motion_cmd_pkg::REG_STORED_COORDINATE_TYPE_IDX:  nxt_s.stored_coordinate_type_idx = reg_wdata_i[7:0];
        motion_cmd_pkg::REG_STORED_COORDINATE_TYPE_DATA: co_we = 1'b1;
        default: ;
      endcase
    end

    // Register reads; unmapped reads return zero
    if (reg_re_i) begin
      unique case (reg_addr_i)
        motion_cmd_pkg::REG_ACCU:      nxt_s.rdata = s_ff.accu;
        motion_cmd_pkg::REG_XREG:      nxt_s.rdata = s_ff.xreg;
        motion_cmd_pkg::REG_TGT_POS:   nxt_s.rdata = s_ff.tgt_pos;
        motion_cmd_pkg::REG_TGT_VEL:   nxt_s.rdata = s_ff.tgt_vel;
        motion_cmd_pkg::REG_STATUS: begin
          nxt_s.rdata[motion_cmd_pkg::ST_VEL_MODE]  = s_ff.vel_mode;
          nxt_s.rdata[motion_cmd_pkg::ST_DIR_RIGHT] = s_ff.dir_right;
          nxt_s.rdata[motion_cmd_pkg::ST_SIV_IGN]   = s_ff.siv_ign;
        end
        motion_cmd_pkg::REG_UVAR_IDX:  nxt_s.rdata = {24'h00_0000, s_ff.uvar_idx};
        motion_cmd_pkg::REG_UVAR_DATA: nxt_s.rdata = s_ff.uvar_rd;
        motion_cmd_pkg::REG_STORED_COORDINATE_TYPE_IDX: nxt_s.rdata = {24'h00_0000, s_ff.stored_coordinate_type_idx};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    unique case (s_ff.st)
      S_RX: begin
        // R14 frame assembly and checksum
        if (rx_valid_i && s_ff.rx_ready) begin
          nxt_s.cnt = s_ff.cnt + 4'h1;
          nxt_s.sum = s_ff.sum + rx_b;
          unique case (s_ff.cnt)
            4'h0: begin
              nxt_s.addr_ok = (rx_b == MOD_ADDR);
              nxt_s.sum     = rx_b;
            end
            4'h1: nxt_s.instr = rx_b;
            4'h2: nxt_s.typ = rx_b;
            4'h3: nxt_s.bank = rx_b;
            4'h4, 4'h5, 4'h6, 4'h7: nxt_s.val = {s_ff.val[23:0], rx_b};
            default: begin
              nxt_s.cnt = 4'h0;
              if (s_ff.addr_ok && (rx_b == s_ff.sum) && known_op(s_ff.instr, s_ff.typ)) begin
                nxt_s.st        = S_EXEC;
                nxt_s.from_host = 1'b1;
              end
            end
          endcase
        end else if (prog_valid_i && s_ff.prog_ready && !rx_valid_i) begin
          // Host bytes take precedence over the stored program
          nxt_s.instr     = prog_instr_i;
          nxt_s.typ       = prog_type_i;
          nxt_s.bank      = prog_bank_i;
          nxt_s.val       = prog_value_i;
          nxt_s.from_host = 1'b0;
          if (known_op(prog_instr_i, prog_type_i)) begin
            nxt_s.st = S_EXEC;
          end else begin
            nxt_s.done = 1'b1;
          end
        end
      end
      S_EXEC: begin
        nxt_s.st = s_ff.from_host ? S_REPLY : S_RX;
        nxt_s.done = !s_ff.from_host;
        nxt_s.txcnt = 4'h0;
        nxt_s.txsum = 8'h00;
        unique case (s_ff.instr)
          motion_cmd_pkg::OP_MOVE_ACCU_POS: begin
            // R01 type selects the move
            if (s_ff.typ == motion_cmd_pkg::STORED_STORED_COORDINATE_TYPE_TYPE) begin
              // R04 coordinate fetch, data next cycle
              nxt_s.st   = S_STORED_COORDINATE_TYPE;
              nxt_s.done = 1'b0;
            end else begin
              // R05 target position load; R07 leaves velocity mode
              nxt_s.vel_mode = 1'b0;
              nxt_s.pos_load = 1'b1;
              // R07 a stop in this cycle loses to the move
              nxt_s.tgt_vel  = s_ff.tgt_vel;
              nxt_s.vel_load = 1'b0;
              if (s_ff.typ == motion_cmd_pkg::RELATIVE_MOVE_TYPE) begin
                // R03 R06 offset added with 32-bit wrap
                nxt_s.tgt_pos = 32'(act_pos_i + s_ff.accu);
              end else begin
                nxt_s.tgt_pos = s_ff.accu;
              end
            end
          end
          motion_cmd_pkg::OP_ROTATE_LEFT_ACC, motion_cmd_pkg::OP_ROTATE_RIGHT_ACC: begin
            // R10 velocity mode then target velocity; R11 unscaled pps
            nxt_s.vel_mode = 1'b1;
            nxt_s.tgt_vel  = s_ff.accu;
            nxt_s.vel_load = 1'b1;
            // R08 R09 direction from opcode only
            nxt_s.dir_right = (s_ff.instr == motion_cmd_pkg::OP_ROTATE_RIGHT_ACC);
          end
          default: begin
            // R12 R13 store only when X within 0 to 255
            if (s_ff.xreg[31:8] == 24'h00_0000) begin
              uv_we = 1'b1;
              nxt_s.siv_ign = 1'b0;
            end else begin
              nxt_s.siv_ign = 1'b1;
            end
          end
        endcase
      end
      S_STORED_COORDINATE_TYPE: begin
        // R04 R05 stored coordinate becomes target
        nxt_s.tgt_pos  = co_q;
        nxt_s.vel_mode = 1'b0;
        nxt_s.pos_load = 1'b1;
        nxt_s.tgt_vel  = s_ff.tgt_vel;
        nxt_s.vel_load = 1'b0;
        nxt_s.st       = s_ff.from_host ? S_REPLY : S_RX;
        nxt_s.done     = !s_ff.from_host;
      end
      S_REPLY: begin
        // R02 R15 reply streams while motion proceeds
        unique case (s_ff.txcnt)
          4'h0: tx_b = HOST_ADDR;
          4'h1: tx_b = MOD_ADDR;
          4'h2: tx_b = motion_cmd_pkg::STATUS_OK;
          4'h3: tx_b = s_ff.instr;
          4'h8: tx_b = s_ff.txsum;
          default: tx_b = 8'h00;
        endcase
        if (!s_ff.tx_valid || tx_ready_i) begin
          if (s_ff.txcnt > motion_cmd_pkg::REPLY_LAST) begin
            nxt_s.tx_valid = 1'b0;
            nxt_s.st       = S_RX;
          end else begin
            nxt_s.tx_byte  = tx_b;
            nxt_s.tx_valid = 1'b1;
            nxt_s.txsum    = s_ff.txsum + tx_b;
            nxt_s.txcnt    = s_ff.txcnt + 4'h1;
          end
        end
      end
      default: nxt_s.st = S_RX;
    endcase

    nxt_s.rx_ready   = (nxt_s.st == S_RX);
    nxt_s.prog_ready = (nxt_s.st == S_RX) && (nxt_s.cnt == 4'h0);

    if (rst_i) begin
      nxt_s = '0;
      nxt_s.st = S_RX;
      uv_we = 1'b0;
      co_we = 1'b0;
    end
  end

  // Whole state registered at once; reset handled in the copy above
  always_ff @(posedge clk_i) begin
    s_ff <= nxt_s;
  end

  assign rx_ready_o   = s_ff.rx_ready;
  assign tx_byte_o    = s_ff.tx_byte;
  assign tx_valid_o   = s_ff.tx_valid;
  assign prog_ready_o = s_ff.prog_ready;
  assign prog_done_o  = s_ff.done;
  assign target_pos_o = s_ff.tgt_pos;
  assign target_vel_o = s_ff.tgt_vel;
  assign vel_mode_o   = s_ff.vel_mode;
  assign dir_right_o  = s_ff.dir_right;
  assign pos_load_o   = s_ff.pos_load;
  assign vel_load_o   = s_ff.vel_load;
  assign reg_rdata_o  = s_ff.rdata;

endmodule : accu_motion_cmd

// ### accu_motion_cmd_assertions.sv
// Assertion checker for the accumulator motion command block
module accu_motion_cmd_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        rx_ready_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic        stop_req_i,
  input wire logic [31:0] target_pos_o,
  input wire logic [31:0] target_vel_o,
  input wire logic        vel_mode_o,
  input wire logic        pos_load_o,
  input wire logic        vel_load_o,
  input wire logic        reg_re_i,
  input wire logic [31:0] reg_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_halt;
    vel_load_o && vel_mode_o && target_vel_o == 32'h0;
  endsequence
  sequence s_head;
    tx_byte_o == motion_cmd_pkg::DEF_HOST_ADDR && !rx_ready_o;
  endsequence
  property p_stop;
    stop_req_i && rx_ready_o |=> s_halt;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_head;
    $rose(tx_valid_o) |-> s_head;
  endproperty
  a_head: assert property (p_head) else $error("bad reply head");
  property p_busy;
    tx_valid_o |-> !rx_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("receive during reply");
  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte lost");
  property p_vmode;
    vel_load_o |-> vel_mode_o;
  endproperty
  a_vmode: assert property (p_vmode) else $error("velocity without mode");
  property p_pmode;
    pos_load_o |-> !vel_mode_o;
  endproperty
  a_pmode: assert property (p_pmode) else $error("move left velocity mode");
  property p_phold;
    !pos_load_o && !$past(rst_i) |-> $stable(target_pos_o);
  endproperty
  a_phold: assert property (p_phold) else $error("target moved unloaded");
  property p_vhold;
    !vel_load_o && !$past(rst_i) |-> $stable(target_vel_o);
  endproperty
  a_vhold: assert property (p_vhold) else $error("velocity moved unloaded");
  property p_rdidle;
    !$past(reg_re_i) |-> reg_rdata_o == 32'h0;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read data outside slot");
endmodule : accu_motion_cmd_checker

bind accu_motion_cmd accu_motion_cmd_checker checker_inst (.clk_i, .rst_i, .rx_ready_o, .tx_byte_o, .tx_valid_o,
  .tx_ready_i, .stop_req_i, .target_pos_o, .target_vel_o, .vel_mode_o, .pos_load_o, .vel_load_o, .reg_re_i,
  .reg_rdata_o);

// ### host_model.sv
// Host side model: sends command frames, gathers replies
module host_model (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] reply_q[$];
  bit         slow = 1'h0;
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'h0;
    tx_ready_o = 1'h0;
  end
  // Slow host toggles ready to stall replies
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) reply_q.push_back(tx_byte_i);
    tx_ready_o <= slow ? ~tx_ready_o : 1'h1;
  end
  task automatic put(input logic [7:0] b);
    rx_byte_o <= b;
    rx_valid_o <= 1'h1;
    @(posedge clk_i);
    while (!rx_ready_i) @(posedge clk_i);
  endtask : put
  task automatic send(input logic [7:0] ad, op, ty, bk, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] f[8];
    logic [7:0] s;
    f = '{ad, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0]};
    s = 8'h00;
    foreach (f[i]) begin
      put(f[i]);
      s += f[i];
    end
    put(s ^ bad);
    rx_valid_o <= 1'h0;
    // Released line inverted, never stale
    rx_byte_o <= ~(s ^ bad);
  endtask : send
endmodule : host_model

// ### accumulator_motion_commands_test.sv
// Self-checking bench for the accumulator motion command block
module accumulator_motion_commands_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'h0, rst_i = 1'h1, stop_req_i = 1'h0, reg_we_i = 1'h0, reg_re_i = 1'h0;
  logic [7:0]  reg_addr_i = 8'h00, rx_byte_i, tx_byte_o;
  logic [31:0] act_pos_i = 32'h0, reg_wdata_i = 32'h0, target_pos_o, target_vel_o, reg_rdata_o;
  logic        rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, vel_mode_o, dir_right_o;
  logic [31:0] m_pos = 32'h0, m_vel = 32'h0, m_uv[int];
  logic [7:0]  ops[5] = '{8'h2E, 8'h2E, 8'h2E, 8'h32, 8'h33};
  bit          m_vm = 1'h0, m_dir = 1'h0;
  logic        prog_valid_i = 1'h0, prog_ready_o, prog_done_o;
  logic [7:0]  prog_instr_i = 8'h00, prog_type_i = 8'h00, prog_bank_i = 8'h00;
  logic [31:0] prog_value_i = 32'h0;
  int          n_mismatch = 0, checked = 0, seed = 6122;
  accu_motion_cmd accu_motion_cmd_inst (.clk_i, .rst_i, .rx_byte_i, .rx_valid_i, .rx_ready_o, .tx_byte_o,
    .tx_valid_o, .tx_ready_i, .prog_valid_i, .prog_instr_i, .prog_type_i, .prog_bank_i, .prog_value_i,
    .prog_ready_o, .prog_done_o, .act_pos_i, .stop_req_i,
    .target_pos_o, .target_vel_o, .vel_mode_o, .dir_right_o, .pos_load_o(), .vel_load_o(), .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);
  host_model host_model_inst (.clk_i, .rx_ready_i(rx_ready_o), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Strobe lasts one cycle; read data taken at the following edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= w;
    reg_re_i <= !w;
    @(posedge clk_i);
    reg_we_i <= 1'h0;
    reg_re_i <= 1'h0;
    @(posedge clk_i);
    q = reg_rdata_o;
  endtask : bus
  task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v, input logic [7:0] bad);
    logic [7:0] ex[9];
    int n;
    ex = '{8'h02, 8'h01, 8'h64, op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h67 + op};
    n = 0;
    host_model_inst.send(8'h01, op, ty, bk, v, bad);
    while (host_model_inst.reply_q.size() < 9 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (bad != 8'h00) chk(host_model_inst.reply_q.size(), 0);
    else foreach (ex[i]) chk(host_model_inst.reply_q.pop_front(), ex[i]);
    @(posedge clk_i);
  endtask : cmd
  task automatic cmp_state();
    chk(target_pos_o, m_pos);
    chk(target_vel_o, m_vel);
    chk({31'h0, vel_mode_o}, {31'h0, m_vm});
    if (m_vm) chk({31'h0, dir_right_o}, {31'h0, m_dir});
  endtask : cmp_state
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [31:0] q, a, p, d;
    logic [31:0] xs[4];
    logic [7:0]  bk;
    int          k;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    bus(1'h0, motion_cmd_pkg::REG_TGT_POS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'h0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < 15; i++) begin
      k = i % 5;
      a = $random(seed);
      p = $random(seed);
      d = $random(seed);
      bk = (k < 2) ? 8'h00 : (i == 2) ? 8'hFF : d[7:0];
      act_pos_i <= p;
      host_model_inst.slow = i[0];
      bus(1'h1, motion_cmd_pkg::REG_ACCU, a, q);
      if (k == 2) begin
        bus(1'h1, motion_cmd_pkg::REG_STORED_COORDINATE_TYPE_IDX, {24'h0, bk}, q);
        bus(1'h1, motion_cmd_pkg::REG_STORED_COORDINATE_TYPE_DATA, d, q);
      end
      cmd(ops[k], (k < 3) ? 8'(k) : d[15:8], bk, d, 8'h00);
      m_pos = (k == 0) ? a : (k == 1) ? p + a : (k == 2) ? d : m_pos;
      m_vel = (k > 2) ? a : m_vel;
      m_vm = k > 2;
      if (k > 2) m_dir = k == 4;
      cmp_state();
      if (k == 0) begin
        stop_req_i <= 1'h1;
        @(posedge clk_i);
        stop_req_i <= 1'h0;
        @(posedge clk_i);
        m_vm = 1'h1;
        m_vel = 32'h0;
        cmp_state();
      end
    end
    xs = '{32'h0, 32'hFF, 32'h100, 32'hFFFFFFFF};
    foreach (xs[j]) begin
      d = $random(seed);
      bus(1'h1, motion_cmd_pkg::REG_XREG, xs[j], q);
      cmd(8'h37, d[31:24], d[23:16], d, 8'h00);
      if (j < 2) m_uv[j * 255] = d;
      bus(1'h0, motion_cmd_pkg::REG_STATUS, 32'h0, q);
      chk({31'h0, q[2]}, {31'h0, j > 1});
    end
    // out of range leaves store intact
    foreach (m_uv[x]) begin
      bus(1'h1, motion_cmd_pkg::REG_UVAR_IDX, 32'(x), q);
      repeat (2) @(posedge clk_i);
      bus(1'h0, motion_cmd_pkg::REG_UVAR_DATA, 32'h0, q);
      chk(q, m_uv[x]);
    end
    d = $random(seed);
    bus(1'h1, motion_cmd_pkg::REG_ACCU, d, q);
    prog_instr_i <= 8'h32;
    prog_type_i <= d[7:0];
    prog_bank_i <= d[15:8];
    prog_value_i <= ~d;
    prog_valid_i <= 1'h1;
    @(posedge clk_i);
    chk({31'h0, prog_ready_o}, 32'h1);
    prog_valid_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk({31'h0, prog_done_o}, 32'h1);
    m_vm = 1'h1;
    m_vel = d;
    m_dir = 1'h0;
    cmp_state();
    @(posedge clk_i);
    chk({31'h0, prog_done_o}, 32'h0);
    prog_instr_i <= 8'h2E;
    prog_type_i <= 8'h03;
    prog_valid_i <= 1'h1;
    @(posedge clk_i);
    prog_valid_i <= 1'h0;
    @(posedge clk_i);
    chk({31'h0, prog_done_o}, 32'h1);
    cmp_state();
    bus(1'h1, motion_cmd_pkg::REG_ACCU, 32'h1234, q);
    cmd(8'h2E, 8'h00, 8'h00, 32'h0, 8'h5A);
    cmp_state();
    give_verdict();
  end
endmodule : accumulator_motion_commands_test
